/* hdl/accel_ctrl.sv */
// sample format, sample buffer and interrupt pin control with axi4-lite
//
// Contract
// - samples reported sign-extended in output registers
// - buffer enabled supports only six to twelve bits
// - decode resolution field, fourteen reduced when buffered
// - decode range field, reserved codes refused
// - buffer features need enable; reset always acts
// - buffer flags report the live count even while disabled
// - threshold field sets event count, host programs 1-31
// - normal mode accepts samples while room remains
// - watermark mode drops samples at threshold
// - enable off writes output registers, on buffers
// - buffer reset clears contents asynchronously, pointers on the next clock
// - drive type selects open-drain or push-pull
// - polarity selects active low or high
// - wake enable interrupts on sniff to wake
// - new sample enable interrupts on each accepted sample
// - empty enable interrupts at count zero
// - full enable interrupts at count 32
// - level enable interrupts at threshold
// - single wake enable interrupts on activity there
// - buffer write clock runs only while enabled
// - buffer entries twelve bits, full at 32
//
// Decided for this implementation: the AXI4-Lite slave port.
module accel_ctrl #(
  parameter int DEPTH = accel_ctrl_pkg::BUF_DEPTH,
  parameter int WIDTH = accel_ctrl_pkg::BUF_WIDTH
) (
  // clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // sample and motion events from the sensing core
  input  wire logic        i_sample_valid,
  input  wire logic [15:0] i_sample_x,
  input  wire logic [15:0] i_sample_y,
  input  wire logic [15:0] i_sample_z,
  input  wire logic        i_wake_event,
  input  wire logic        i_activity_event,
  input  wire logic        i_single_wake_mode,
  // axi4-lite slave
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // interrupt pin, three-signal form
  input  wire logic        i_irq_pin,
  output logic             o_irq_pin,
  output logic             o_irq_pin_oe_n
);
  localparam int AW = $clog2(DEPTH);

  // pointer and flag widths assume exactly this geometry
  if (DEPTH != 32 || WIDTH != 12) begin : g_size_check
    $error("accel_ctrl: buffer must be 32 deep and 12 wide");
  end

  typedef struct packed {
    accel_ctrl_pkg::range_res_t rr;
    accel_ctrl_pkg::buf_ctrl_t  bc;
    accel_ctrl_pkg::irq_ctrl_t  ic;
    logic [5:0][7:0]            out_data;
    logic                       new_data;
    logic [4:0]                 pend;   // wake,new,empty,full,level; single_wake_mode has its own flag
    logic                       single_wake_mode_pend;
    logic [AW-1:0]              wptr;
    logic [AW-1:0]              rptr;
    logic [AW:0]                count;
    logic [1:0]                 axis;
    logic                       aw_held;
    logic [7:0]                 aw_addr;
    logic                       w_held;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       pin;
    logic                       pin_oe_n;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [WIDTH-1:0] buf_rdata;
  logic             buf_we;
  logic [WIDTH-1:0] buf_wdata;
  logic             buf_clr_n;
  logic             buf_ce;
  logic             unused_pin;

  // shift a signed 16-bit value down to the selected width, sign kept
  function automatic logic [15:0] fmt(input logic [15:0] v,
                                      input logic [2:0]  res,
                                      input logic        buffered);
    logic [15:0] s;
    s = v;
    case (res)
      accel_ctrl_pkg::RES_6:  s = 16'($signed(v) >>> 10);
      accel_ctrl_pkg::RES_7:  s = 16'($signed(v) >>> 9);
      accel_ctrl_pkg::RES_8:  s = 16'($signed(v) >>> 8);
      accel_ctrl_pkg::RES_10: s = 16'($signed(v) >>> 6);
      accel_ctrl_pkg::RES_12: s = 16'($signed(v) >>> 4);
      accel_ctrl_pkg::RES_14: s = buffered ? 16'($signed(v) >>> 4)
                                           : 16'($signed(v) >>> 2);
      default:                s = 16'($signed(v) >>> 4);
    endcase
    return s;
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] nw,
                                       input logic       en);
    return en ? nw : old;
  endfunction

  // contents clear asynchronously from the reset bit; pointers clear on the next clock
  assign buf_clr_n = i_rst_n & ~st_reg.bc.buf_reset;
  // write side stalls with the enable so storage stays quiet
  assign buf_ce    = i_ce & st_reg.bc.buf_en;
  assign unused_pin = i_irq_pin;

  always_comb begin
    logic        full;
    logic        at_level;
    logic        rd_pop;
    logic        accept;
    logic [15:0] sx;
    logic [15:0] sy;
    logic [15:0] sz;
    logic        asserted;
    logic        wr_go;
    full = 1'b0;
    at_level = 1'b0;
    rd_pop = 1'b0;
    accept = 1'b0;
    sx = '0;
    sy = '0;
    sz = '0;
    asserted = 1'b0;
    wr_go = 1'b0;
    st_next = st_reg;
    buf_we = 1'b0;
    buf_wdata = '0;

    full     = (st_reg.count == (AW+1)'(DEPTH));
    at_level = (st_reg.count >= {1'b0, st_reg.bc.buffer_level_threshold});
    sx = fmt(i_sample_x, st_reg.rr.res, st_reg.bc.buf_en);
    sy = fmt(i_sample_y, st_reg.rr.res, st_reg.bc.buf_en);
    sz = fmt(i_sample_z, st_reg.rr.res, st_reg.bc.buf_en);

    // sample path
    if (i_sample_valid) begin
      if (!st_reg.bc.buf_en) begin
        st_next.out_data = {sz, sy, sx};
        st_next.new_data = 1'b1;
      end else begin
        // watermark drops at threshold, normal only when full
        accept = !full && !(st_reg.bc.watermark && at_level);
        if (accept) begin
          buf_we    = 1'b1;
          buf_wdata = sx[WIDTH-1:0];
          st_next.new_data = 1'b1;
        end
      end
    end

    // axi write: accept address and data in either order
    if (i_awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = i_awaddr;
    end
    if (i_wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = i_wdata;
      st_next.w_strb = i_wstrb;
    end
    wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    if (wr_go) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = 2'h0;
      case (st_reg.aw_addr[7:2])
        accel_ctrl_pkg::RANGE_RES_IDX[5:0]: begin
          if (st_reg.w_data[6:4] <= accel_ctrl_pkg::RANGE_MAX_CODE &&
              st_reg.w_data[2:0] <= accel_ctrl_pkg::RES_14) begin
            st_next.rr.range = st_reg.w_data[6:4];
            st_next.rr.res   = st_reg.w_data[2:0];
          end else begin
            st_next.bresp = 2'h2;
          end
        end
        accel_ctrl_pkg::BUF_CTRL_IDX[5:0]: begin
          st_next.bc = merge(st_reg.bc, st_reg.w_data[7:0],
                             st_reg.w_strb[0]);
        end
        accel_ctrl_pkg::IRQ_CTRL_IDX[5:0]: begin
          st_next.ic = merge(st_reg.ic, st_reg.w_data[7:0],
                             st_reg.w_strb[0]);
        end
        accel_ctrl_pkg::EVENT_ACK_IDX[5:0]: begin
          // ack bits clear pending flags; a coincident event wins below
          st_next.pend = st_reg.pend & ~st_reg.w_data[4:0];
          st_next.single_wake_mode_pend = st_reg.single_wake_mode_pend & ~st_reg.w_data[5];
          // a sample landing in the same cycle keeps the flag set
          if (st_reg.w_data[6] &&
              !(i_sample_valid && (accept || !st_reg.bc.buf_en))) begin
            st_next.new_data = 1'b0;
          end
        end
        default: st_next.bresp = 2'h2;
      endcase
    end
    if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
    end

    // axi read
    if (i_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = 2'h0;
      st_next.rdata  = '0;
      if (i_araddr[7:2] >= accel_ctrl_pkg::OUT_DATA_IDX0[5:0] &&
          i_araddr[7:2] <= accel_ctrl_pkg::OUT_DATA_IDX1[5:0]) begin
        st_next.rdata[7:0] = st_reg.out_data[
          3'(i_araddr[7:2] - accel_ctrl_pkg::OUT_DATA_IDX0[5:0])];
      end else begin
        case (i_araddr[7:2])
          accel_ctrl_pkg::RANGE_RES_IDX[5:0]:
            st_next.rdata[7:0] = {1'b0, st_reg.rr.range, 1'b0, st_reg.rr.res};
          accel_ctrl_pkg::BUF_CTRL_IDX[5:0]:
            st_next.rdata[7:0] = st_reg.bc;
          accel_ctrl_pkg::IRQ_CTRL_IDX[5:0]:
            st_next.rdata[7:0] = st_reg.ic;
          accel_ctrl_pkg::STATUS_IDX[5:0]: begin
            // flags keep reporting even with the buffer off
            st_next.rdata[0] = st_reg.new_data;
            st_next.rdata[1] = (st_reg.count == '0);
            st_next.rdata[2] = full;
            st_next.rdata[3] = at_level;
            st_next.rdata[9:4] = {st_reg.single_wake_mode_pend, st_reg.pend};
            st_next.rdata[15:10] = 6'(st_reg.count);
          end
          accel_ctrl_pkg::BUF_READ_IDX[5:0]: begin
            st_next.rdata[15:0] = {{(16-WIDTH){buf_rdata[WIDTH-1]}},
                                   buf_rdata};
            rd_pop = (st_reg.count != '0) && st_reg.bc.buf_en;
          end
          default: st_next.rresp = 2'h2;
        endcase
      end
    end
    if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end

    // pointer and count bookkeeping
    if (buf_we) begin
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (rd_pop) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(buf_we) - (AW+1)'(rd_pop);

    // event sets come last so they beat a simultaneous clear
    if (i_wake_event && st_reg.ic.wake_irq_en) begin
      st_next.pend[0] = 1'b1;
    end
    if (i_sample_valid && (buf_we || !st_reg.bc.buf_en) &&
        st_reg.ic.new_sample_irq_en) begin
      st_next.pend[1] = 1'b1;
    end
    if (st_reg.bc.buf_en) begin
      if (st_next.count == '0 && st_reg.count != '0 &&
          st_reg.ic.empty_irq_en) begin
        st_next.pend[2] = 1'b1;
      end
      if (st_next.count == (AW+1)'(DEPTH) &&
          st_reg.count != (AW+1)'(DEPTH) && st_reg.ic.full_irq_en) begin
        st_next.pend[3] = 1'b1;
      end
      if (st_next.count == {1'b0, st_reg.bc.buffer_level_threshold} &&
          st_reg.count != st_next.count &&
          st_reg.ic.buffer_level_irq_en) begin
        st_next.pend[4] = 1'b1;
      end
    end
    if (i_activity_event && i_single_wake_mode &&
        st_reg.ic.single_wake_activity_irq_en) begin
      st_next.single_wake_mode_pend = 1'b1;
    end
    // buffer reset bit is self-clearing; counters follow its clear
    if (st_reg.bc.buf_reset) begin
      st_next.bc.buf_reset = 1'b0;
      st_next.wptr  = '0;
      st_next.rptr  = '0;
      st_next.count = '0;
    end

    // pin: level from polarity, enable from drive type
    asserted = (|st_next.pend) || st_next.single_wake_mode_pend;
    st_next.pin = asserted ^ ~st_next.ic.irq_pin_polarity;
    // open-drain only drives the low level
    st_next.pin_oe_n = st_next.ic.irq_pin_drive_type ? 1'b0 : st_next.pin;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
      st_reg.pin <= 1'b1;
      st_reg.pin_oe_n <= 1'b1;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  sample_buf_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .i_mclk  (i_mclk),
    .i_clr_n (buf_clr_n),
    .i_ce    (buf_ce),
    .i_we    (buf_we),
    .i_waddr (st_reg.wptr),
    .i_wdata (buf_wdata),
    .i_raddr (st_reg.rptr),
    .o_rdata (buf_rdata)
  );

  assign o_awready      = !st_reg.aw_held;
  assign o_wready       = !st_reg.w_held;
  assign o_bvalid       = st_reg.bvalid;
  assign o_bresp        = st_reg.bresp;
  assign o_arready      = !st_reg.rvalid;
  assign o_rvalid       = st_reg.rvalid;
  assign o_rdata        = st_reg.rdata;
  assign o_rresp        = st_reg.rresp;
  assign o_irq_pin      = st_reg.pin;
  assign o_irq_pin_oe_n = st_reg.pin_oe_n;
endmodule // accel_ctrl

/* hdl/accel_ctrl_pkg.sv */
// package: register map, field layout, reset values and carriers
package accel_ctrl_pkg;
  // register indices; a register's byte address is four times its index
  localparam logic [7:0] RANGE_RES_IDX  = 8'h15;
  localparam logic [7:0] BUF_CTRL_IDX   = 8'h16;
  localparam logic [7:0] IRQ_CTRL_IDX   = 8'h17;
  localparam logic [7:0] OUT_DATA_IDX0  = 8'h02;
  localparam logic [7:0] OUT_DATA_IDX1  = 8'h07;
  localparam logic [7:0] STATUS_IDX     = 8'h08;
  localparam logic [7:0] BUF_READ_IDX   = 8'h30;
  localparam logic [7:0] EVENT_ACK_IDX  = 8'h31;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // resolution codes, then the highest legal range code
  localparam logic [2:0] RES_6  = 3'h0;
  localparam logic [2:0] RES_7  = 3'h1;
  localparam logic [2:0] RES_8  = 3'h2;
  localparam logic [2:0] RES_10 = 3'h3;
  localparam logic [2:0] RES_12 = 3'h4;
  localparam logic [2:0] RES_14 = 3'h5;
  localparam logic [2:0] RANGE_MAX_CODE = 3'h4;

  // field positions
  localparam int RES_LSB      = 0;
  localparam int RANGE_LSB    = 4;
  localparam int BUF_MODE_BIT = 5;
  localparam int BUF_EN_BIT   = 6;
  localparam int BUF_RST_BIT  = 7;
  localparam int DRIVE_BIT    = 0;
  localparam int POL_BIT      = 1;
  localparam int WAKE_BIT     = 2;
  localparam int NEW_BIT      = 3;
  localparam int EMPTY_BIT    = 4;
  localparam int FULL_BIT     = 5;
  localparam int LEVEL_BIT    = 6;
  localparam int SINGLE_WAKE_MODE_BIT    = 7;

  localparam int BUF_DEPTH = 32;
  localparam int BUF_WIDTH = 12;

  typedef struct packed {
    logic [2:0] range;
    logic [2:0] res;
  } range_res_t;

  typedef struct packed {
    logic       buf_reset;
    logic       buf_en;
    logic       watermark;
    logic [4:0] buffer_level_threshold;
  } buf_ctrl_t;

  typedef struct packed {
    logic       single_wake_activity_irq_en;
    logic       buffer_level_irq_en;
    logic       full_irq_en;
    logic       empty_irq_en;
    logic       new_sample_irq_en;
    logic       wake_irq_en;
    logic       irq_pin_polarity;
    logic       irq_pin_drive_type;
  } irq_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } sample_t;
endpackage : accel_ctrl_pkg

/* hdl/sample_buf_mem.sv */
// sample buffer storage: one write port, registered read, clearable
module sample_buf_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_clr_n,
  input  wire logic             i_ce,
  // write port
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  // read port
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // contents go to zero under the clear
  always_ff @(posedge i_mclk or negedge i_clr_n) begin
    if (!i_clr_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      o_rdata <= '0;
    end else if (i_ce) begin
      if (i_we) begin
        mem_reg[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_reg[i_raddr];
    end
  end
endmodule // sample_buf_mem

/* tb/accel_ctrl_properties.sv */
// checker: register write shadow and interrupt pin relations
module accel_ctrl_chk (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  // axi write side
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic [7:0]  i_awaddr,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic        o_bvalid,
  input wire logic [1:0]  o_bresp,
  // events and pin
  input wire logic        i_sample_valid,
  input wire logic        i_wake_event,
  input wire logic        i_activity_event,
  input wire logic        i_single_wake_mode,
  input wire logic        o_irq_pin,
  input wire logic        o_irq_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_RNG = accel_ctrl_pkg::RANGE_RES_IDX << 2;
  localparam logic [7:0] A_IRQ = accel_ctrl_pkg::IRQ_CTRL_IDX << 2;
  logic [7:0]                wa_reg;
  logic [7:0]                wd_reg;
  logic                      none;
  accel_ctrl_pkg::irq_ctrl_t ic_reg;
  // shadow commits on the same edge as the design, so pin relations line up
  assign none = (ic_reg[7:2] == 6'h00);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wa_reg <= 8'h00;
      wd_reg <= 8'h00;
      ic_reg <= '0;
    end else begin
      if (i_awvalid && o_awready) wa_reg <= i_awaddr;
      if (i_wvalid && o_wready) wd_reg <= i_wdata[7:0];
      // both halves held and no response yet: the write lands this edge
      if (!o_awready && !o_wready && !o_bvalid && wa_reg == A_IRQ)
        ic_reg <= wd_reg;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_od_low;
    !ic_reg.irq_pin_drive_type && !$past(ic_reg.irq_pin_drive_type)
      && !o_irq_pin_oe_n |-> !o_irq_pin;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain drove high");
  property p_pp_drive;
    ic_reg.irq_pin_drive_type && $past(ic_reg.irq_pin_drive_type)
      |-> !o_irq_pin_oe_n;
  endproperty
  a_pp_drive: assert property (p_pp_drive)
    else $error("push-pull released");
  property p_idle;
    none && $past(none) && $past(ic_reg.irq_pin_polarity)
      == ic_reg.irq_pin_polarity
      |-> o_irq_pin_oe_n || (o_irq_pin != ic_reg.irq_pin_polarity);
  endproperty
  a_idle: assert property (p_idle)
    else $error("pin asserted, none enabled");
  property p_new;
    ic_reg.new_sample_irq_en && i_sample_valid
      |-> ##[1:3] (o_irq_pin == ic_reg.irq_pin_polarity);
  endproperty
  a_new: assert property (p_new)
    else $error("no sample interrupt");
  property p_wake;
    ic_reg.wake_irq_en && i_wake_event
      |-> ##[1:3] (o_irq_pin == ic_reg.irq_pin_polarity);
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake interrupt");
  sequence s_single_wake_mode;
    ic_reg.single_wake_activity_irq_en && i_activity_event
      && i_single_wake_mode;
  endsequence
  property p_single_wake_mode;
    s_single_wake_mode |-> ##[1:3] (o_irq_pin == ic_reg.irq_pin_polarity);
  endproperty
  a_single_wake_mode: assert property (p_single_wake_mode)
    else $error("no activity interrupt");
  property p_rng_rsv;
    o_bvalid && wa_reg == A_RNG
      && wd_reg[6:4] > accel_ctrl_pkg::RANGE_MAX_CODE |-> o_bresp == 2'h2;
  endproperty
  a_rng_rsv: assert property (p_rng_rsv)
    else $error("range code taken");
  property p_res_rsv;
    o_bvalid && wa_reg == A_RNG
      && wd_reg[2:0] > accel_ctrl_pkg::RES_14 |-> o_bresp == 2'h2;
  endproperty
  a_res_rsv: assert property (p_res_rsv)
    else $error("res code taken");
  property p_codes_ok;
    o_bvalid && wa_reg == A_RNG && wd_reg[7] == 1'b0 && wd_reg[3] == 1'b0
      && wd_reg[6:4] <= accel_ctrl_pkg::RANGE_MAX_CODE
      && wd_reg[2:0] <= accel_ctrl_pkg::RES_14 |-> o_bresp == 2'h0;
  endproperty
  a_codes_ok: assert property (p_codes_ok)
    else $error("valid code refused");
  c_slverr: cover property (o_bvalid && o_bresp == 2'h2);
  c_pp_high: cover property (!o_irq_pin_oe_n && o_irq_pin);
  c_od_low: cover property (!ic_reg.irq_pin_drive_type && !o_irq_pin_oe_n);
endmodule // accel_ctrl_chk

bind accel_ctrl accel_ctrl_chk chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .i_wdata(i_wdata), .o_bvalid(o_bvalid),
  .o_bresp(o_bresp), .i_sample_valid(i_sample_valid),
  .i_wake_event(i_wake_event), .i_activity_event(i_activity_event),
  .i_single_wake_mode(i_single_wake_mode), .o_irq_pin(o_irq_pin),
  .o_irq_pin_oe_n(o_irq_pin_oe_n));

/* tb/accel_ctrl_tb.sv */
// self-checking bench: register port, sample stream, interrupt line
module accel_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_RNG = accel_ctrl_pkg::RANGE_RES_IDX << 2;
  localparam logic [7:0] A_BUF = accel_ctrl_pkg::BUF_CTRL_IDX << 2;
  localparam logic [7:0] A_IRQ = accel_ctrl_pkg::IRQ_CTRL_IDX << 2;
  localparam logic [7:0] A_ST  = accel_ctrl_pkg::STATUS_IDX << 2;
  localparam logic [7:0] A_POP = accel_ctrl_pkg::BUF_READ_IDX << 2;
  localparam logic [7:0] A_ACK = accel_ctrl_pkg::EVENT_ACK_IDX << 2;
  localparam logic [7:0] A_XLO = accel_ctrl_pkg::OUT_DATA_IDX0 << 2;
  localparam logic [7:0] A_XHI = (accel_ctrl_pkg::OUT_DATA_IDX0 + 8'h01) << 2;
  logic        clk = 1'b0, rst_n = 1'b0, sv = 1'b0, wk = 1'b0, act = 1'b0;
  logic        swm = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [15:0] sx = 16'h0000, sy = 16'h0000, sz = 16'h0000;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h3a;
  logic        awready, wready, bvalid, arready, rvalid, pin, oe_n, line;
  logic [1:0]  bresp, rresp;
  logic [33:0] em, mm;
  logic [33:0] eq[$], mq[$];
  logic [1:0]  bq[$];
  logic [15:0] bufq[$];
  int          error_cnt = 0, n_tests = 0;
  int          bits_tab[6] = '{6, 7, 8, 10, 12, 14};

  always #12.5 clk = ~clk;

  accel_ctrl uut (.i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_sample_valid(sv), .i_sample_x(sx), .i_sample_y(sy), .i_sample_z(sz),
    .i_wake_event(wk), .i_activity_event(act), .i_single_wake_mode(swm),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'h1),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_irq_pin(line), .o_irq_pin(pin), .o_irq_pin_oe_n(oe_n));
  irq_pull_model pull (.i_pin(pin), .i_pin_oe_n(oe_n), .o_line(line));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] fmt(input logic [15:0] x, input int b);
    return 16'($signed(x) >>> (16 - b));
  endfunction
  task automatic check(input string nm, input logic [33:0] s,
                       input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bail();
    error_cnt++;
    $display("[ERR] handshake exp answer got timeout");
    give_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    logic dn;
    bq.push_back(er);
    @(posedge clk);
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    dn = 1'b0;
    for (n = 0; n < 64 && !dn; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        dn = 1'b1;
      end
    end
    if (!dn) bail();
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input logic [15:0] m, input logic [1:0] er);
    int n;
    logic dn;
    eq.push_back({er, 16'h0, e});
    mq.push_back({2'h3, 16'h0, m});
    @(posedge clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    dn = 1'b0;
    for (n = 0; n < 64 && !dn; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        dn = 1'b1;
      end
    end
    if (!dn) bail();
  endtask
  task automatic smp(input logic [15:0] x);
    @(posedge clk);
    sv <= 1'b1; sx <= x; sy <= 16'(rnd()); sz <= 16'(rnd());
    @(posedge clk);
    sv <= 1'b0;
  endtask
  task automatic pls(input logic w);
    @(posedge clk);
    if (w) wk <= 1'b1;
    else act <= 1'b1;
    @(posedge clk);
    wk <= 1'b0; act <= 1'b0;
  endtask
  task automatic pin_is(input logic v);
    repeat (3) @(posedge clk);
    check("irq line", 34'(line), 34'(v));
  endtask

  // expectations were queued by the driver in issue order
  always @(posedge clk) begin
    if (bvalid && bready)
      check("bresp", 34'(bresp), 34'(bq.pop_front()));
    if (rvalid && rready) begin
      em = eq.pop_front();
      mm = mq.pop_front();
      check("rdata", {rresp, rdata} & mm, em & mm);
    end
  end

  initial begin
    int k;
    logic [15:0] x;
    logic [7:0] v;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_RNG, 16'h0, 16'h00ff, 2'h0);
    rd(A_BUF, 16'h0, 16'h00ff, 2'h0);
    rd(A_IRQ, 16'h0, 16'h00ff, 2'h0);
    rd(A_ST, 16'h0002, 16'hfc06, 2'h0);
    rd(8'hfc, 16'h0, 16'h0, 2'h2);
    wr(8'hf8, 8'h00, 2'h2);
    $display("defaults done");
    for (k = 0; k < 6; k++) begin
      v = {1'b0, 3'(k % 5), 1'b0, 3'(k)};
      wr(A_RNG, v, 2'h0);
      rd(A_RNG, {8'h0, v}, 16'h00ff, 2'h0);
      x = 16'(rnd());
      smp(x);
      x = fmt(x, bits_tab[k]);
      rd(A_XLO, {8'h0, x[7:0]}, 16'h00ff, 2'h0);
      rd(A_XHI, {8'h0, x[15:8]}, 16'h00ff, 2'h0);
    end
    wr(A_RNG, 8'h50, 2'h2);
    wr(A_RNG, 8'h06, 2'h2);
    rd(A_RNG, 16'h0005, 16'h00ff, 2'h0);
    $display("format done");
    wr(A_IRQ, 8'h23, 2'h0);
    wr(A_BUF, 8'h44, 2'h0);
    for (k = 0; k < 33; k++) begin
      x = 16'(rnd());
      smp(x);
      if (k < 32) bufq.push_back(fmt(x, 12));
    end
    rd(A_ST, {6'd32, 10'h084}, 16'hfc86, 2'h0);
    pin_is(1'b1);
    wr(A_ACK, 8'h7f, 2'h0);
    wr(A_IRQ, 8'h13, 2'h0);
    pin_is(1'b0);
    for (k = 0; k < 32; k++)
      rd(A_POP, bufq.pop_front(), 16'hffff, 2'h0);
    rd(A_ST, 16'h0042, 16'hfc46, 2'h0);
    pin_is(1'b1);
    $display("fill and drain done");
    wr(A_ACK, 8'h7f, 2'h0);
    wr(A_IRQ, 8'h40, 2'h0);
    wr(A_BUF, 8'h63, 2'h0);
    for (k = 0; k < 6; k++) begin
      x = 16'(rnd());
      smp(x);
      if (k < 3) bufq.push_back(fmt(x, 12));
    end
    rd(A_ST, {6'd3, 10'h100}, 16'hfd00, 2'h0);
    pin_is(1'b0);
    rd(A_POP, bufq.pop_front(), 16'hffff, 2'h0);
    bufq.delete();
    wr(A_BUF, 8'he3, 2'h0);
    rd(A_ST, 16'h0002, 16'hfc06, 2'h0);
    rd(A_POP, 16'h0000, 16'hffff, 2'h0);
    $display("watermark done");
    wr(A_ACK, 8'h7f, 2'h0);
    wr(A_BUF, 8'h03, 2'h0);
    x = 16'(rnd());
    smp(x);
    x = fmt(x, 14);
    rd(A_ST, 16'h0002, 16'hfc06, 2'h0);
    rd(A_XLO, {8'h0, x[7:0]}, 16'h00ff, 2'h0);
    pin_is(1'b1);
    $display("disabled done");
    wr(A_ACK, 8'h7f, 2'h0);
    wr(A_IRQ, 8'h80, 2'h0);
    pls(1'b0);
    pin_is(1'b1);
    swm <= 1'b1;
    pls(1'b0);
    pin_is(1'b0);
    wr(A_ACK, 8'h7f, 2'h0);
    pin_is(1'b1);
    wr(A_IRQ, 8'h04, 2'h0);
    pls(1'b1);
    pin_is(1'b0);
    wr(A_ACK, 8'h7f, 2'h0);
    wr(A_IRQ, 8'h0b, 2'h0);
    pin_is(1'b0);
    smp(16'(rnd()));
    pin_is(1'b1);
    $display("events done");
    give_verdict();
  end
endmodule // accel_ctrl_tb

/* tb/irq_pull_model.sv */
// host board side of the interrupt line: pull-up and resolved level
module irq_pull_model (
  // pin as driven by the device
  input  wire logic i_pin,
  input  wire logic i_pin_oe_n,
  // resolved line level
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released line floats up to the pull-up level
  assign o_line = i_pin_oe_n ? 1'b1 : i_pin;
endmodule // irq_pull_model
